// File: rtl/gpp_pkg.sv
// constants shared across the general purpose port block
//
// Notes on behaviour
// - each pin's synchronized level is readable at all times, input or output
// - input path: latch transparent on high clock, then registered on rising edge
// - external pin edge reaches the sample bit after half to one and half periods
// - a written output value reaches the sample bit two periods after the latch write, one after the pad
// - sleep clamps each digital input to ground ahead of the input buffer
// - clamp bypassed on pins whose external interrupt is enabled or overridden
// - without pull-up override, pull-up on only for direction/latch/disable = 010
// - with pull-up override, its value alone switches the pull-up
// - direction override decides the driver enable, else the direction bit
// - driven value is the value override when enabled, else the output latch
// - toggle override from a peripheral inverts the pin's output latch bit
// - input enable override decides input enable, else sleep state decides
// - alternate digital input taken after the input buffer, before the synchronizer
// - analog path goes straight to the pad with no digital gating
// - strobes shared per port, clock/clamp/pull-up disable global, overrides per pin
// - pin 7 clock, 1 data out, 0 data in, 5/2 interrupts, 7..0 pin-change
// - direction one means output; reset tri-states all pins
// - writing one into the sample location inverts that pin's output latch
// - input pin with latch one gets pull-up unless globally disabled
package gpp_pkg;
    localparam int GPP_W = 8;
    localparam int GPP_AW = 2;
    localparam logic [GPP_AW-1:0] GPP_ADDR_SAMPLE = 2'h0;
    localparam logic [GPP_AW-1:0] GPP_ADDR_DIR = 2'h1;
    localparam logic [GPP_AW-1:0] GPP_ADDR_LATCH = 2'h2;
    localparam logic [GPP_AW-1:0] GPP_ADDR_CTRL = 2'h3;
    localparam logic [GPP_W-1:0] GPP_RST_BYTE = 8'h00;
    localparam int GPP_CTRL_PUD_BIT = 4;
    localparam int GPP_PIN_SCK = 7;
    localparam int GPP_PIN_MOSI = 1;
    localparam int GPP_PIN_MISO = 0;
    localparam int GPP_PIN_IRQ_TWO = 5;
    localparam int GPP_PIN_IRQ_ONE = 2;
endpackage : gpp_pkg

// File: rtl/gpp_pin.sv
// one port pin: override muxing, sleep clamp and two-stage synchronizer
`timescale 1ns/1ps
module gpp_pin
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // pad side
    input  wire logic pad_in,
    // register bits and global controls
    input  wire logic pin_direction_bit,
    input  wire logic pin_output_latch_bit,
    input  wire logic global_pullup_disable,
    input  wire logic sleep_clamp,
    // overrides of this pin
    input  wire logic pullup_override_enable,
    input  wire logic pullup_override_value,
    input  wire logic direction_override_enable,
    input  wire logic direction_override_value,
    input  wire logic value_override_enable,
    input  wire logic value_override_value,
    input  wire logic input_enable_override_enable,
    input  wire logic input_enable_override_value,
    // results
    output logic      drive_en,
    output logic      drive_val,
    output logic      pullup_en,
    output logic      sample_bit,
    output logic      alt_digital_input,
    output logic      analog_pad_signal
);
    logic drive_en_r, drive_en_nxt;
    logic drive_val_r, drive_val_nxt;
    logic pullup_r, pullup_nxt;
    logic sync_lat_r, sync_lat_nxt;
    logic sample_r, sample_nxt;
    logic in_en;

    // driver, value and pull-up selection
    always_comb begin
        drive_en_nxt = direction_override_enable ? direction_override_value : pin_direction_bit;
        drive_val_nxt = value_override_enable ? value_override_value : pin_output_latch_bit;
        if (pullup_override_enable) begin
            pullup_nxt = pullup_override_value;
        end else begin
            pullup_nxt = !pin_direction_bit && pin_output_latch_bit && !global_pullup_disable;
        end
        if (rst) begin
            drive_en_nxt = 1'b0;
            drive_val_nxt = 1'b0;
            pullup_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        drive_en_r <= drive_en_nxt;
        drive_val_r <= drive_val_nxt;
        pullup_r <= pullup_nxt;
    end

    // input enable: the override wins over the sleep controller
    assign in_en = input_enable_override_enable ? input_enable_override_value : !sleep_clamp;
    // clamped to ground in sleep so a floating pad cannot burn current
    assign alt_digital_input = pad_in && in_en;
    // analog path sees the raw pad, never the clamp
    assign analog_pad_signal = pad_in;

    // latch stage: falling-edge capture stands in for the high-transparent latch;
    // a pin we drive feeds the latch from the driver so read back takes one period
    always_comb begin
        sync_lat_nxt = drive_en_r ? drive_val_r : alt_digital_input;
        sample_nxt = sync_lat_r;
        if (rst) begin
            sync_lat_nxt = 1'b0;
            sample_nxt = 1'b0;
        end
    end

    always_ff @(negedge mclk) begin
        sync_lat_r <= sync_lat_nxt;
    end

    always_ff @(posedge mclk) begin
        sample_r <= sample_nxt;
    end

    assign drive_en = drive_en_r;
    assign drive_val = drive_val_r;
    assign pullup_en = pullup_r;
    assign sample_bit = sample_r;
endmodule : gpp_pin

// File: rtl/gpp_port.sv
// eight-pin general purpose port with register port and peripheral overrides
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module gpp_port
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register port, shared by all pins of the port
    input  wire logic [GPP_AW-1:0] reg_addr,
    input  wire logic [GPP_W-1:0]  reg_wdata,
    input  wire logic              port_write_strobe,
    input  wire logic              port_read_strobe,
    output logic      [GPP_W-1:0]  reg_rdata,
    // global controls
    input  wire logic              sleep_clamp,
    // pads
    input  wire logic [GPP_W-1:0]  pad_in,
    output logic      [GPP_W-1:0]  pad_out,
    output logic      [GPP_W-1:0]  pad_oe,
    output logic      [GPP_W-1:0]  pad_pullup_en,
    // per-pin overrides from peripherals
    input  wire logic [GPP_W-1:0]  pullup_override_enable,
    input  wire logic [GPP_W-1:0]  pullup_override_value,
    input  wire logic [GPP_W-1:0]  direction_override_enable,
    input  wire logic [GPP_W-1:0]  direction_override_value,
    input  wire logic [GPP_W-1:0]  value_override_enable,
    input  wire logic [GPP_W-1:0]  value_override_value,
    input  wire logic [GPP_W-1:0]  toggle_override_enable,
    input  wire logic [GPP_W-1:0]  input_enable_override_enable,
    input  wire logic [GPP_W-1:0]  input_enable_override_value,
    // external interrupt enables of the interrupt pins
    input  wire logic              ext_irq_one_en,
    input  wire logic              ext_irq_two_en,
    // alternate inputs to peripherals
    output logic      [GPP_W-1:0]  alt_digital_input,
    output logic      [GPP_W-1:0]  analog_pad_signal,
    output logic      [GPP_W-1:0]  pin_change_irq_sources,
    output logic                   ext_irq_one,
    output logic                   ext_irq_two,
    output logic                   spi_sck_in,
    output logic                   spi_mosi_in,
    output logic                   spi_miso_in
);
    logic [GPP_W-1:0] dir_r, dir_nxt;
    logic [GPP_W-1:0] latch_r, latch_nxt;
    logic             pud_r, pud_nxt;
    logic [GPP_W-1:0] rdata_r, rdata_nxt;
    logic [GPP_W-1:0] sample;
    logic [GPP_W-1:0] ie_oe;
    logic [GPP_W-1:0] ie_ov;
    logic [GPP_W-1:0] toggle_mask;

    // interrupt pins keep their input alive in sleep while their external interrupt is enabled
    always_comb begin
        ie_oe = input_enable_override_enable;
        ie_ov = input_enable_override_value;
        ie_oe[GPP_PIN_IRQ_ONE] = input_enable_override_enable[GPP_PIN_IRQ_ONE] || ext_irq_one_en;
        ie_ov[GPP_PIN_IRQ_ONE] = ext_irq_one_en || input_enable_override_value[GPP_PIN_IRQ_ONE];
        ie_oe[GPP_PIN_IRQ_TWO] = input_enable_override_enable[GPP_PIN_IRQ_TWO] || ext_irq_two_en;
        ie_ov[GPP_PIN_IRQ_TWO] = ext_irq_two_en || input_enable_override_value[GPP_PIN_IRQ_TWO];
    end

    // register writes; toggles stack on top of a plain write in the same cycle
    always_comb begin
        dir_nxt = dir_r;
        latch_nxt = latch_r;
        pud_nxt = pud_r;
        toggle_mask = toggle_override_enable;
        if (port_write_strobe) begin
            if (reg_addr == GPP_ADDR_SAMPLE) begin
                toggle_mask = toggle_mask | reg_wdata;
            end else if (reg_addr == GPP_ADDR_DIR) begin
                dir_nxt = reg_wdata;
            end else if (reg_addr == GPP_ADDR_LATCH) begin
                latch_nxt = reg_wdata;
            end else if (reg_addr == GPP_ADDR_CTRL) begin
                pud_nxt = reg_wdata[GPP_CTRL_PUD_BIT];
            end
        end
        latch_nxt = latch_nxt ^ toggle_mask;
        if (rst) begin
            dir_nxt = GPP_RST_BYTE;
            latch_nxt = GPP_RST_BYTE;
            pud_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        dir_r <= dir_nxt;
        latch_r <= latch_nxt;
        pud_r <= pud_nxt;
    end

    // read data: valid only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_nxt = GPP_RST_BYTE;
        if (port_read_strobe) begin
            if (reg_addr == GPP_ADDR_SAMPLE) begin
                rdata_nxt = sample;
            end else if (reg_addr == GPP_ADDR_DIR) begin
                rdata_nxt = dir_r;
            end else if (reg_addr == GPP_ADDR_LATCH) begin
                rdata_nxt = latch_r;
            end else if (reg_addr == GPP_ADDR_CTRL) begin
                rdata_nxt = GPP_RST_BYTE;
                rdata_nxt[GPP_CTRL_PUD_BIT] = pud_r;
            end
        end
        if (rst) begin
            rdata_nxt = GPP_RST_BYTE;
        end
    end

    always_ff @(posedge mclk) begin
        rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // one pin slice per bit; overrides are individual, pud and clamp shared
    for (genvar i = 0; i < GPP_W; i++) begin : g_pin
        gpp_pin u_pin (
            .mclk                         (mclk),
            .rst                          (rst),
            .pad_in                       (pad_in[i]),
            .pin_direction_bit            (dir_r[i]),
            .pin_output_latch_bit         (latch_r[i]),
            .global_pullup_disable        (pud_r),
            .sleep_clamp                  (sleep_clamp),
            .pullup_override_enable       (pullup_override_enable[i]),
            .pullup_override_value        (pullup_override_value[i]),
            .direction_override_enable    (direction_override_enable[i]),
            .direction_override_value     (direction_override_value[i]),
            .value_override_enable        (value_override_enable[i]),
            .value_override_value         (value_override_value[i]),
            .input_enable_override_enable (ie_oe[i]),
            .input_enable_override_value  (ie_ov[i]),
            .drive_en                     (pad_oe[i]),
            .drive_val                    (pad_out[i]),
            .pullup_en                    (pad_pullup_en[i]),
            .sample_bit                   (sample[i]),
            .alt_digital_input            (alt_digital_input[i]),
            .analog_pad_signal            (analog_pad_signal[i])
        );
    end

    // alternate function assignment of this port
    assign pin_change_irq_sources = alt_digital_input;
    assign ext_irq_one = alt_digital_input[GPP_PIN_IRQ_ONE];
    assign ext_irq_two = alt_digital_input[GPP_PIN_IRQ_TWO];
    assign spi_sck_in = alt_digital_input[GPP_PIN_SCK];
    assign spi_mosi_in = alt_digital_input[GPP_PIN_MOSI];
    assign spi_miso_in = alt_digital_input[GPP_PIN_MISO];
endmodule : gpp_port

// File: testbench/gpp_asserts.sv
// concurrent checks on the ports of the eight-pin port
`timescale 1ns/1ps
module gpp_asserts
    import gpp_pkg::*;
(
    // clock, reset and register port
    input wire logic         mclk,
    input wire logic         rst,
    input wire logic         port_read_strobe,
    input wire logic [7:0]   reg_rdata,
    // pads and global controls
    input wire logic         sleep_clamp,
    input wire logic [7:0]   pad_in,
    input wire logic [7:0]   pad_out,
    input wire logic [7:0]   pad_oe,
    input wire logic [7:0]   pad_pullup_en,
    // overrides
    input wire logic [7:0]   pullup_override_enable,
    input wire logic [7:0]   pullup_override_value,
    input wire logic [7:0]   direction_override_enable,
    input wire logic [7:0]   direction_override_value,
    input wire logic [7:0]   value_override_enable,
    input wire logic [7:0]   value_override_value,
    input wire logic [7:0]   input_enable_override_enable,
    input wire logic [7:0]   input_enable_override_value,
    input wire logic         ext_irq_one_en,
    input wire logic         ext_irq_two_en,
    // alternate inputs
    input wire logic [7:0]   alt_digital_input,
    input wire logic [7:0]   analog_pad_signal,
    input wire logic [7:0]   pin_change_irq_sources,
    input wire logic         ext_irq_one,
    input wire logic         ext_irq_two,
    input wire logic         spi_sck_in,
    input wire logic         spi_mosi_in,
    input wire logic         spi_miso_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // interrupt pins 5 and 2 keep their input while the interrupt is enabled
    wire [7:0] irq_m  = {2'h0, ext_irq_two_en, 2'h0, ext_irq_one_en, 2'h0};
    wire [7:0] in_off = ((input_enable_override_enable & ~input_enable_override_value)
                        | (~input_enable_override_enable & {8{sleep_clamp}})) & ~irq_m;
    wire [7:0] in_on  = ~in_off;

    reset_clear_a: assert property (disable iff (1'b0) rst |=> pad_oe == 8'h00
        && pad_pullup_en == 8'h00 && reg_rdata == 8'h00) else $error("pins not released by reset");
    rdata_idle_a: assert property (!port_read_strobe |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    pullup_ovr_a: assert property (1'b1 |=> (pad_pullup_en & $past(pullup_override_enable))
        == $past(pullup_override_enable & pullup_override_value)) else $error("pull-up override ignored");
    dir_ovr_a: assert property (1'b1 |=> (pad_oe & $past(direction_override_enable))
        == $past(direction_override_enable & direction_override_value)) else $error("direction override ignored");
    val_ovr_a: assert property (1'b1 |=> (pad_out & pad_oe & $past(value_override_enable))
        == (pad_oe & $past(value_override_enable & value_override_value))) else $error("value override ignored");
    input_off_a: assert property ((alt_digital_input & in_off) == 8'h00)
        else $error("disabled input not clamped low");
    input_pass_a: assert property ((alt_digital_input & in_on) == (pad_in & in_on))
        else $error("enabled input not passed");
    alt_route_a: assert property (pin_change_irq_sources == alt_digital_input
        && spi_sck_in == alt_digital_input[GPP_PIN_SCK]
        && spi_mosi_in == alt_digital_input[GPP_PIN_MOSI] && spi_miso_in == alt_digital_input[GPP_PIN_MISO]
        && ext_irq_one == alt_digital_input[GPP_PIN_IRQ_ONE] && ext_irq_two == alt_digital_input[GPP_PIN_IRQ_TWO])
        else $error("alternate routing wrong");
    analog_path_a: assert property (analog_pad_signal == pad_in) else $error("analog path gated");
    clamp_irq_c: cover property (sleep_clamp && ext_irq_one_en && ext_irq_two_en);
    read_data_c: cover property (port_read_strobe ##1 reg_rdata != 8'h00);
    dir_ovr_c: cover property (direction_override_enable != 8'h00);
endmodule : gpp_asserts

bind gpp_port gpp_asserts chk_u (
    .mclk                         (mclk),
    .rst                          (rst),
    .port_read_strobe             (port_read_strobe),
    .reg_rdata                    (reg_rdata),
    .sleep_clamp                  (sleep_clamp),
    .pad_in                       (pad_in),
    .pad_out                      (pad_out),
    .pad_oe                       (pad_oe),
    .pad_pullup_en                (pad_pullup_en),
    .pullup_override_enable       (pullup_override_enable),
    .pullup_override_value        (pullup_override_value),
    .direction_override_enable    (direction_override_enable),
    .direction_override_value     (direction_override_value),
    .value_override_enable        (value_override_enable),
    .value_override_value         (value_override_value),
    .input_enable_override_enable (input_enable_override_enable),
    .input_enable_override_value  (input_enable_override_value),
    .ext_irq_one_en               (ext_irq_one_en),
    .ext_irq_two_en               (ext_irq_two_en),
    .alt_digital_input            (alt_digital_input),
    .analog_pad_signal            (analog_pad_signal),
    .pin_change_irq_sources       (pin_change_irq_sources),
    .ext_irq_one                  (ext_irq_one),
    .ext_irq_two                  (ext_irq_two),
    .spi_sck_in                   (spi_sck_in),
    .spi_mosi_in                  (spi_mosi_in),
    .spi_miso_in                  (spi_miso_in)
);

// File: testbench/gpp_board.sv
// board model: external drivers, pull-ups and floating pads
`timescale 1ns/1ps
module gpp_board (
    // clock and port side
    input  wire logic       mclk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup_en,
    // external drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad_in
);
    logic [7:0] flip = 8'h55;
    // a floating pad keeps changing, so stale values never pass
    always @(posedge mclk) flip <= ~flip;
    // port driver wins, then board driver, then pull-up, else float
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & (pad_pullup_en | flip))));
endmodule : gpp_board

// File: testbench/tb_top.sv
// self-checking bench of the eight-pin port
`timescale 1ns/1ps
module tb_top
    import gpp_pkg::*;
;
    logic              mclk, rst, we, re, sclamp, irq1_en, irq2_en, rd_d = 1'b0;
    logic [GPP_AW-1:0] addr;
    logic [7:0]        wdata, rdata, pout, poe, ppu, pin, ext_en, ext_val, lat, m, t, v;
    logic [7:0]        ovr [9];
    logic [7:0]        exp_q [$];
    int                fail_count = 0, n_tests = 0;

    gpp_port dut_u (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .port_write_strobe(we),
        .port_read_strobe(re), .reg_rdata(rdata), .sleep_clamp(sclamp), .pad_in(pin), .pad_out(pout),
        .pad_oe(poe), .pad_pullup_en(ppu), .pullup_override_enable(ovr[0]), .pullup_override_value(ovr[1]),
        .direction_override_enable(ovr[2]), .direction_override_value(ovr[3]), .value_override_enable(ovr[4]),
        .value_override_value(ovr[5]), .toggle_override_enable(ovr[6]), .input_enable_override_enable(ovr[7]),
        .input_enable_override_value(ovr[8]), .ext_irq_one_en(irq1_en), .ext_irq_two_en(irq2_en),
        .alt_digital_input(), .analog_pad_signal(), .pin_change_irq_sources(), .ext_irq_one(),
        .ext_irq_two(), .spi_sck_in(), .spi_mosi_in(), .spi_miso_in());
    gpp_board board_u (.mclk(mclk), .pad_out(pout), .pad_oe(poe), .pad_pullup_en(ppu),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pin));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    // one bus cycle; every call assigns each strobe once, so no glitch between calls
    task automatic bus(input logic w, input logic r, input logic [GPP_AW-1:0] a, input logic [7:0] d);
        we <= w;
        re <= r;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
    endtask : bus

    task automatic rd(input logic [GPP_AW-1:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_d)
            chk(rdata, exp_q.pop_front());
        rd_d <= re;
    end

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #40000;
        fail_count++;
        close_out();
    end

    initial begin
        {rst, we, re, sclamp, irq1_en, irq2_en} = 6'h20;
        {addr, wdata, ext_en, ext_val} = '0;
        foreach (ovr[i]) ovr[i] = 8'h00;
        void'($urandom(32'ha1b8));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(GPP_ADDR_DIR, GPP_RST_BYTE);
        rd(GPP_ADDR_LATCH, GPP_RST_BYTE);
        $display("test reset done");
        // driven pins read back through the synchronizer
        lat = 8'($urandom);
        bus(1'b1, 1'b0, GPP_ADDR_DIR, 8'hff);
        bus(1'b1, 1'b0, GPP_ADDR_LATCH, lat);
        repeat (3) bus(1'b0, 1'b0, 2'h0, 8'h00);
        rd(GPP_ADDR_SAMPLE, lat);
        chk(poe, 8'hff);
        // toggling through the sample location and the peripheral
        m = 8'($urandom);
        t = 8'($urandom);
        bus(1'b1, 1'b0, GPP_ADDR_SAMPLE, m);
        rd(GPP_ADDR_LATCH, lat ^ m);
        ovr[6] <= t;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        ovr[6] <= 8'h00;
        rd(GPP_ADDR_LATCH, lat ^ m ^ t);
        repeat (3) bus(1'b0, 1'b0, 2'h0, 8'h00);
        rd(GPP_ADDR_SAMPLE, lat ^ m ^ t);
        $display("test output done");
        // external level seen within one and a half periods; the driver lets go one cycle after the write
        bus(1'b1, 1'b0, GPP_ADDR_DIR, 8'h00);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        v = 8'($urandom);
        ext_en <= 8'hff;
        ext_val <= v;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        rd(GPP_ADDR_SAMPLE, v);
        $display("test input done");
        // pull-ups on input pins and their global disable
        ext_en <= 8'h00;
        bus(1'b1, 1'b0, GPP_ADDR_LATCH, 8'hff);
        repeat (3) bus(1'b0, 1'b0, 2'h0, 8'h00);
        chk(ppu, 8'hff);
        rd(GPP_ADDR_SAMPLE, 8'hff);
        bus(1'b1, 1'b0, GPP_ADDR_CTRL, 8'(1 << GPP_CTRL_PUD_BIT));
        rd(GPP_ADDR_CTRL, 8'(1 << GPP_CTRL_PUD_BIT));
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        chk(ppu, 8'h00);
        $display("test pullup done");
        // random overrides, clamp and pads, judged by the checker
        repeat (40) begin
            foreach (ovr[i]) ovr[i] <= 8'($urandom);
            {sclamp, irq1_en, irq2_en} <= 3'($urandom);
            ext_en <= 8'($urandom);
            ext_val <= 8'($urandom);
            bus(1'b0, 1'b0, 2'h0, 8'h00);
        end
        $display("test override done");
        repeat (2) bus(1'b0, 1'b0, 2'h0, 8'h00);
        close_out();
    end
endmodule : tb_top
